/* File: core/led_matrix_device.sv */
// LED matrix driver control end: paged registers, shutdown, test mode, scan and de-ghost pulls
// How it works
// RULE1: Pull-up and pull-down strengths chosen at 0Fh/10h.
// RULE2: Pulls connect only while their output is off.
// RULE3: Serial reset pin high holds interface in reset.
// RULE4: Shutdown never alters any register contents.
// RULE5: Soft-off bit zero blanks all current sources.
// RULE6: Hard-off pin low disables analog, registers stay accessible.
// RULE7: Test registers reachable only with key F7 stored.
// RULE8: Host selects page three before test registers.
// RULE9: Scan hold code nonzero parks one switch on; codes 0Dh-0Fh leave all switches off.
// RULE10: Host periodically rewrites key, clears test registers.
// RULE11: Trim fields in E2h and E3h, default normally.
// RULE12: Thermal raise bit D4, protect-off bit D0.
// RULE13: PWM 8.4kHz default, D4 of 00h selects 26.7kHz.
`timescale 1ns/1ps
`include "led_ctrl_cfg.svh"
module led_matrix_device #(
  parameter int unsigned PWM_SLOW_CYC = `PWM_SLOW_CYC,
  parameter int unsigned PWM_FAST_CYC = `PWM_FAST_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  led_link_if.device link,
  output logic [11:0] scan_switch_pins,
  output logic [11:0] scan_switch_pullup_en,
  output logic [11:0] current_source_pins,
  output logic [11:0] current_source_pulldown_en,
  output logic [7:0] pullup_strength,
  output logic [7:0] pulldown_strength,
  output logic analog_enable,
  output logic test_mode,
  output logic [2:0] current_trim,
  output logic [3:0] reference_trim_field,
  output logic [3:0] oscillator_trim_field,
  output logic thermal_limit_raise_bit,
  output logic thermal_protect_off_bit,
  output logic pwm_fast
);
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] config_reg;
    logic [7:0] pullup_sel;
    logic [7:0] pulldown_sel;
    logic [7:0] thermal;
    logic [7:0] unlock;
    logic [7:0] scan_hold;
    logic [7:0] cs_trim;
    logic [7:0] ro_trim;
    logic ack;
    logic acked;
    logic [7:0] rdata;
    logic [14:0] pwm_cnt;
    logic [3:0] scan_idx;
    logic [11:0] sw_on;
    logic [11:0] cs_on;
    logic analog_en;
  } state_s;

  state_s r;
  state_s next_r;
  logic unlocked;
  logic in_page3;
  logic test_addr;
  logic [14:0] period;
  logic [7:0] rd_mux;

  assign unlocked = (r.unlock == `UNLOCK_KEY); // RULE7
  assign in_page3 = (r.page == `PAGE_THREE); // RULE8
  assign test_addr = (link.addr == `SCAN_HOLD_OFF) || (link.addr == `CURRENT_TRIM_OFF) ||
    (link.addr == `REF_OSC_TRIM_OFF) || (link.addr == `THERMAL_OFF);
  // Fast PWM shortens the period; the counter wraps at whichever is selected
  assign period = r.config_reg[`PWM_FAST_BIT] ? 15'(PWM_FAST_CYC - 1) : 15'(PWM_SLOW_CYC - 1); // RULE13

  // Read multiplexer; a locked test register or another page reads as zero
  always_comb begin
    rd_mux = 8'h00;
    if (link.addr == `PAGE_SEL_OFF) begin
      rd_mux = r.page;
    end else if (in_page3 && !(test_addr && !unlocked)) begin // RULE7
      unique case (link.addr)
        `CONFIG_OFF: rd_mux = r.config_reg;
        `PULLUP_SEL_OFF: rd_mux = r.pullup_sel;
        `PULLDOWN_SEL_OFF: rd_mux = r.pulldown_sel;
        `THERMAL_OFF: rd_mux = {3'h0, r.thermal[`LIMIT_RAISE_BIT], 3'h0, r.thermal[`PROTECT_OFF_BIT]};
        `UNLOCK_OFF: rd_mux = r.unlock;
        `SCAN_HOLD_OFF: rd_mux = {4'h0, r.scan_hold[3:0]};
        `CURRENT_TRIM_OFF: rd_mux = {5'h00, r.cs_trim[2:0]};
        `REF_OSC_TRIM_OFF: rd_mux = r.ro_trim;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  // Next-state logic: register access, PWM divider, scan and output drive
  always_comb begin
    next_r = r;
    next_r.ack = 1'b0;
    // Shutdown paths never touch register fields, so contents survive either mode
    next_r.page = r.page; // RULE4
    if (link.serial_reset_pin) begin // RULE3
      next_r.acked = 1'b0;
      next_r.rdata = 8'h00;
    end else if (!link.req) begin
      next_r.acked = 1'b0;
    end else if (!r.acked) begin
      next_r.ack = 1'b1;
      next_r.acked = 1'b1;
      next_r.rdata = rd_mux;
      // Accesses still land during hard-off; only the analog side is idle
      if (link.we) begin // RULE6
        if (link.addr == `PAGE_SEL_OFF) begin
          next_r.page = link.wdata;
        end else if (in_page3 && !(test_addr && !unlocked)) begin // RULE7
          unique case (link.addr)
            `CONFIG_OFF: next_r.config_reg = link.wdata;
            `PULLUP_SEL_OFF: next_r.pullup_sel = link.wdata; // RULE1
            `PULLDOWN_SEL_OFF: next_r.pulldown_sel = link.wdata; // RULE1
            `THERMAL_OFF: next_r.thermal = link.wdata; // RULE12
            `UNLOCK_OFF: next_r.unlock = link.wdata;
            `SCAN_HOLD_OFF: next_r.scan_hold = link.wdata;
            `CURRENT_TRIM_OFF: next_r.cs_trim = link.wdata; // RULE11
            `REF_OSC_TRIM_OFF: next_r.ro_trim = link.wdata; // RULE11
            default: next_r.rdata = 8'h00;
          endcase
        end
      end
    end
    next_r.analog_en = link.hard_off_pin; // RULE6
    // One scan step per PWM period; a held switch overrides the rotation, which keeps stepping
    if (r.pwm_cnt >= period) begin
      next_r.pwm_cnt = 15'h0000;
      next_r.scan_idx = (r.scan_idx == 4'(`SW_COUNT - 1)) ? 4'h0 : r.scan_idx + 4'h1;
    end else begin
      next_r.pwm_cnt = r.pwm_cnt + 15'h0001;
    end
    next_r.sw_on = 12'h000;
    if (!link.hard_off_pin) begin // RULE6
      next_r.sw_on = 12'h000;
    end else if (unlocked && r.scan_hold[3:0] != 4'h0 && r.scan_hold[3:0] <= 4'hC) begin // RULE9
      next_r.sw_on[r.scan_hold[3:0] - 4'h1] = 1'b1;
    end else if (r.scan_hold[3:0] == 4'h0 || !unlocked) begin
      next_r.sw_on[r.scan_idx] = 1'b1; // RULE9
    end
    // Sources drive for the first half of each period unless blanked
    if (!r.config_reg[`SOFT_OFF_BIT] || !link.hard_off_pin) begin // RULE5
      next_r.cs_on = 12'h000;
    end else begin
      next_r.cs_on = (r.pwm_cnt < (period >> 1)) ? 12'hFFF : 12'h000;
    end
  end

  // Pulls are the complement of drive while the hard-off pin is high and all off in hard-off, so no current burns through them
  genvar g;
  generate
    for (g = 0; g < `SW_COUNT; g++) begin : g_pull
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          scan_switch_pullup_en[g] <= 1'b0;
          current_source_pulldown_en[g] <= 1'b0;
        end else begin
          scan_switch_pullup_en[g] <= !next_r.sw_on[g] && link.hard_off_pin; // RULE2
          current_source_pulldown_en[g] <= !next_r.cs_on[g] && link.hard_off_pin; // RULE2
        end
      end
    end
  endgenerate

  // State register; only the chip reset clears configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.config_reg <= `REG_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign link.ack = r.ack;
  assign link.rdata = r.rdata;
  assign scan_switch_pins = r.sw_on;
  assign current_source_pins = r.cs_on;
  assign pullup_strength = r.pullup_sel;
  assign pulldown_strength = r.pulldown_sel;
  assign analog_enable = r.analog_en;
  assign current_trim = r.cs_trim[2:0];
  assign reference_trim_field = r.ro_trim[7:4];
  assign oscillator_trim_field = r.ro_trim[3:0];
  assign thermal_limit_raise_bit = r.thermal[`LIMIT_RAISE_BIT]; // RULE12
  assign thermal_protect_off_bit = r.thermal[`PROTECT_OFF_BIT]; // RULE12
  assign pwm_fast = r.config_reg[`PWM_FAST_BIT]; // RULE13
  // Test mode has its own flip-flop, loaded from the next key value so it changes with the stored key
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_mode <= 1'b0;
    end else begin
      test_mode <= (next_r.unlock == `UNLOCK_KEY); // RULE7
    end
  end
endmodule

/* File: core/led_matrix_host.sv */
// Host end: AXI4-Lite command registers driving the register link and the recovery sequence
`timescale 1ns/1ps
`include "led_ctrl_cfg.svh"
module led_matrix_host #(
  parameter int unsigned RECOVER_CYC = `RECOVER_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  led_link_if.host link
);
  typedef struct packed {
    logic aw_got;
    logic [31:0] aw;
    logic w_got;
    logic [31:0] wd;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic [3:0] ctrl;
    led_ctrl_pkg::host_state_e st;
    logic seq;
    logic [2:0] step;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] last_rd;
    logic [7:0] page;
    logic [29:0] timer;
  } state_s;

  state_s r;
  state_s next_r;
  logic [16:0] step_cmd;

  // Recovery list: page, key, clear three test registers, relock
  always_comb begin
    unique case (r.step)
      3'h0: step_cmd = {1'b1, `PAGE_SEL_OFF, `PAGE_THREE}; // RULE8
      3'h1: step_cmd = {1'b1, `UNLOCK_OFF, `UNLOCK_KEY}; // RULE10
      3'h2: step_cmd = {1'b1, `SCAN_HOLD_OFF, `CLEAR_VALUE}; // RULE10
      3'h3: step_cmd = {1'b1, `CURRENT_TRIM_OFF, `CLEAR_VALUE}; // RULE11
      3'h4: step_cmd = {1'b1, `REF_OSC_TRIM_OFF, `CLEAR_VALUE}; // RULE11
      default: step_cmd = {1'b1, `UNLOCK_OFF, `CLEAR_VALUE}; // RULE10
    endcase
  end

  always_comb begin
    next_r = r;
    // Bus: address and data taken independently, answer once both are held
    if (s_axi_awvalid && !r.aw_got && !r.bvalid) begin
      next_r.aw_got = 1'b1;
      next_r.aw = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_got && !r.bvalid) begin
      next_r.w_got = 1'b1;
      next_r.wd = s_axi_wdata;
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      unique case (s_axi_araddr[7:0])
        `HOST_CTRL_OFF: next_r.rdata = {28'h0000000, r.ctrl};
        `HOST_STATUS_OFF: next_r.rdata = {16'h0000, r.last_rd, 6'h00, r.seq, r.st};
        default: next_r.rdata = 32'h00000000;
      endcase
    end
    // Sequencer: request held until the one-cycle acknowledge
    if (r.st == led_ctrl_pkg::st_wait && link.ack) begin
      next_r.req = 1'b0;
      next_r.st = led_ctrl_pkg::st_idle;
      next_r.last_rd = link.rdata;
      if (r.we && r.addr == `PAGE_SEL_OFF) begin
        next_r.page = r.wdata;
      end
      next_r.step = r.step + 3'h1;
      if (r.step == 3'h5) begin
        next_r.seq = 1'b0;
      end
    end
    // Periodic recovery timer, armed only when enabled
    if (r.ctrl[`CTRL_AUTO_RECOVER_BIT] && !r.seq) begin
      next_r.timer = (r.timer >= 30'(RECOVER_CYC - 1)) ? 30'h00000000 : r.timer + 30'h00000001;
    end else begin
      next_r.timer = 30'h00000000;
    end
    if (r.st == led_ctrl_pkg::st_idle && r.seq && !r.ctrl[`CTRL_SERIAL_RESET_BIT]) begin // RULE3
      if (r.step == 3'h0 && r.page == `PAGE_THREE) begin
        next_r.step = 3'h1; // RULE8
      end else begin
        next_r.st = led_ctrl_pkg::st_wait;
        next_r.req = 1'b1;
        {next_r.we, next_r.addr, next_r.wdata} = step_cmd;
      end
    end
    if (r.aw_got && r.w_got) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      if (r.aw[7:0] == 8'(`HOST_CTRL_OFF)) begin
        next_r.ctrl = {1'b0, r.wd[2:0]};
        if (r.wd[`CTRL_START_RECOVER_BIT] && !r.seq && r.st == led_ctrl_pkg::st_idle) begin
          next_r.seq = 1'b1;
          next_r.step = 3'h0;
        end
      end else if (r.aw[7:0] == 8'(`HOST_CMD_OFF) && r.st == led_ctrl_pkg::st_idle && !r.seq &&
                   !r.ctrl[`CTRL_SERIAL_RESET_BIT]) begin // RULE3
        next_r.st = led_ctrl_pkg::st_wait;
        next_r.req = 1'b1;
        next_r.we = r.wd[`CMD_WRITE_BIT];
        next_r.addr = r.wd[15:8];
        next_r.wdata = r.wd[7:0];
        next_r.step = 3'h6;
      end
    end
    if (r.timer == 30'(RECOVER_CYC - 1) && !r.seq && r.st == led_ctrl_pkg::st_idle) begin
      next_r.seq = 1'b1; // RULE10
      next_r.step = 3'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.page <= 8'hFF;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready = !r.w_got && !r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = 2'h0;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = 2'h0;
  assign link.req = r.req;
  assign link.we = r.we;
  assign link.addr = r.addr;
  assign link.wdata = r.wdata;
  assign link.serial_reset_pin = r.ctrl[`CTRL_SERIAL_RESET_BIT]; // RULE3
  assign link.hard_off_pin = !r.ctrl[`CTRL_HARD_OFF_BIT];
endmodule

/* File: include/led_ctrl_cfg.svh */
// Offsets, field positions, keys and timing counts of the LED matrix control logic
`ifndef LED_CTRL_CFG_SVH
`define LED_CTRL_CFG_SVH
`define CLK_HZ 200000000
`define PAGE_SEL_OFF 8'hFD
`define PAGE_THREE 8'h03
`define CONFIG_OFF 8'h00
`define PULLUP_SEL_OFF 8'h0F
`define PULLDOWN_SEL_OFF 8'h10
`define THERMAL_OFF 8'h12
`define UNLOCK_OFF 8'hE0
`define SCAN_HOLD_OFF 8'hE1
`define CURRENT_TRIM_OFF 8'hE2
`define REF_OSC_TRIM_OFF 8'hE3
`define UNLOCK_KEY 8'hF7
`define CLEAR_VALUE 8'h00
`define REG_RESET 8'h00
`define SOFT_OFF_BIT 0
`define PWM_FAST_BIT 4
`define LIMIT_RAISE_BIT 4
`define PROTECT_OFF_BIT 0
`define SW_COUNT 12
`define PWM_SLOW_HZ 8400
`define PWM_FAST_HZ_X10 267000
`define PWM_SLOW_CYC (`CLK_HZ / `PWM_SLOW_HZ)
`define PWM_FAST_CYC ((`CLK_HZ / `PWM_FAST_HZ_X10) * 10)
`define RECOVER_S 5
`define RECOVER_CYC (`RECOVER_S * `CLK_HZ)
`define HOST_CMD_OFF 32'h00000000
`define HOST_CTRL_OFF 32'h00000004
`define HOST_STATUS_OFF 32'h00000008
`define CTRL_SERIAL_RESET_BIT 0
`define CTRL_HARD_OFF_BIT 1
`define CTRL_AUTO_RECOVER_BIT 2
`define CTRL_START_RECOVER_BIT 3
`define CMD_WRITE_BIT 16
`endif

/* File: include/led_ctrl_pkg.sv */
// Types for the LED matrix control link; only the host end uses the state type
package led_ctrl_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic {
    st_idle = 1'b0,
    st_wait = 1'b1
  } host_state_e;
endpackage

/* File: include/led_link_if.sv */
// Register access link plus reset and shutdown pins between host and driver
`timescale 1ns/1ps
interface led_link_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  logic serial_reset_pin;
  logic hard_off_pin;
  modport device (input req, input we, input addr, input wdata, input serial_reset_pin, input hard_off_pin,
    output ack, output rdata);
  modport host (output req, output we, output addr, output wdata, output serial_reset_pin, output hard_off_pin,
    input ack, input rdata);
endinterface

/* File: tb/led_link_properties.sv */
// Link handshake and pin properties of the LED matrix host and device pair
`timescale 1ns/1ps
module led_link_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic serial_reset_pin,
  input wire logic hard_off_pin,
  input wire logic [11:0] scan_switch_pins,
  input wire logic [11:0] scan_switch_pullup_en,
  input wire logic [11:0] current_source_pins,
  input wire logic [11:0] current_source_pulldown_en,
  input wire logic analog_enable,
  input wire logic test_mode
);
  logic [7:0] page;
  logic [7:0] next_page;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Page followed from acknowledged writes; forgotten on serial reset to stay on the safe side
  always_comb begin
    next_page = page;
    if (serial_reset_pin) next_page = 8'h00;
    else if (ack && we && addr == 8'hFD) next_page = wdata;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) page <= 8'h00;
    else page <= next_page;
  end
  // A key write: request seen, then its acknowledge while page three is selected
  sequence key_write;
    req && we && addr == 8'hE0 && !ack ##1 ack && page == 8'h03;
  endsequence
  a_ack_follows_req: assert property ($rose(req) && !serial_reset_pin |=> ack)
    else $error("no acknowledge one cycle after request");
  a_ack_single_pulse: assert property (ack |=> !ack)
    else $error("acknowledge longer than one cycle");
  a_reset_blocks_ack: assert property (serial_reset_pin && $past(serial_reset_pin) |-> !ack)
    else $error("acknowledge while serial reset held");
  a_req_held_stable: assert property (req && !ack |=> req && $stable(addr) && $stable(wdata) && $stable(we))
    else $error("request changed before acknowledge");
  a_pullup_gated: assert property (!(|(scan_switch_pins & scan_switch_pullup_en)))
    else $error("pull-up connected on a driving switch");
  a_pulldown_gated: assert property (!(|(current_source_pins & current_source_pulldown_en)))
    else $error("pull-down connected on a driving source");
  a_hard_off_blank: assert property (!hard_off_pin ##1 !hard_off_pin |-> !analog_enable && current_source_pins == 12'h000)
    else $error("analog or sources active in hard shutdown");
  a_key_opens_test: assert property (key_write ##0 wdata == 8'hF7 |-> ##[1:2] test_mode)
    else $error("test mode not entered after key");
  a_bad_key_closes: assert property (key_write ##0 wdata != 8'hF7 |-> ##[1:2] !test_mode)
    else $error("test mode entered without key");
  a_locked_reads_zero: assert property (ack && !we && page == 8'h03 && !test_mode &&
    (addr == 8'h12 || addr == 8'hE1 || addr == 8'hE2 || addr == 8'hE3) |-> rdata == 8'h00)
    else $error("locked test register read nonzero");
endmodule

/* File: tb/led_matrix_test_shutdown_ctrl_tb.sv */
// Self-checking bench: AXI4-Lite host end joined to the LED matrix device end
`timescale 1ns/1ps
`include "led_ctrl_cfg.svh"
module led_matrix_test_shutdown_ctrl_tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, s_wdata, araddr, r_data, rdat, seed, s;
  logic [1:0] bresp, rresp;
  logic [11:0] sw, sw_pu, cs, cs_pd, acc;
  logic [7:0] pu, pd, mpage;
  logic [7:0] mreg [0:255];
  logic aen, tmode, lraise, poff, pfast;
  logic [2:0] ctrim;
  logic [3:0] rtrim, otrim;
  int fails, samples_checked;
  led_link_if link ();
  // Short recovery and PWM periods keep the run brief
  led_matrix_host #(.RECOVER_CYC(200)) led_matrix_host_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(s_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(r_data), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link));
  led_matrix_device #(.PWM_SLOW_CYC(40), .PWM_FAST_CYC(20)) led_matrix_device_inst (.aclk(aclk),
    .aresetn(aresetn), .link(link), .scan_switch_pins(sw), .scan_switch_pullup_en(sw_pu),
    .current_source_pins(cs), .current_source_pulldown_en(cs_pd), .pullup_strength(pu), .pulldown_strength(pd),
    .analog_enable(aen), .test_mode(tmode), .current_trim(ctrim), .reference_trim_field(rtrim),
    .oscillator_trim_field(otrim), .thermal_limit_raise_bit(lraise), .thermal_protect_off_bit(poff),
    .pwm_fast(pfast));
  led_link_properties led_link_properties_inst (.aclk(aclk), .aresetn(aresetn), .req(link.req), .we(link.we),
    .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata),
    .serial_reset_pin(link.serial_reset_pin), .hard_off_pin(link.hard_off_pin), .scan_switch_pins(sw),
    .scan_switch_pullup_en(sw_pu), .current_source_pins(cs), .current_source_pulldown_en(cs_pd),
    .analog_enable(aen), .test_mode(tmode));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic finish_test();
    $display("checked %0d, mismatched %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic tmo();
    chk("handshake in time", 1, 0);
    finish_test();
  endtask
  // Bus cycles: ready is looked at on the falling edge, so the rising edge never races the design
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    bit ta, tw, tb;
    n = 0;
    tb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    s_wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb && n < 100) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      n++;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!tb) tmo();
  endtask
  task automatic axi_rd(input logic [31:0] a);
    int n;
    bit ta, t;
    n = 0;
    t = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!t && n < 100) begin
      @(negedge aclk);
      ta = arvalid && arready;
      t = rvalid;
      rdat = r_data;
      n++;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!t) tmo();
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      axi_rd(`HOST_STATUS_OFF);
      n++;
    end while (rdat[1:0] !== 2'b00 && n < 50);
    if (rdat[1:0] !== 2'b00) tmo();
  endtask
  // Model of the device registers: test registers guarded by the key, masks per field
  function automatic bit lk(input logic [7:0] a);
    return a == 8'h12 || a == 8'hE1 || a == 8'hE2 || a == 8'hE3;
  endfunction
  task automatic dwr(input logic [7:0] a, input logic [7:0] d);
    axi_wr(`HOST_CMD_OFF, {15'h0000, 1'b1, a, d});
    if (a == 8'hFD) mpage = d;
    else if (mpage == 8'h03 && (mreg[8'hE0] == 8'hF7 || !lk(a)))
      mreg[a] = d & (a == 8'h12 ? 8'h11 : a == 8'hE1 ? 8'h0F : a == 8'hE2 ? 8'h07 : 8'hFF);
    idle();
  endtask
  task automatic drd(input logic [7:0] a);
    axi_wr(`HOST_CMD_OFF, {16'h0000, a, 8'h00});
    idle();
    chk("read byte", (lk(a) && mreg[8'hE0] != 8'hF7) ? 8'h00 : mreg[a], rdat[15:8]);
  endtask
  task automatic watch(input int n, input bit src);
    acc = 12'h000;
    repeat (n) begin
      @(negedge aclk);
      acc = acc | (src ? cs : sw);
    end
  endtask
  task automatic mrec();
    mreg[8'hE0] = 8'h00;
    mreg[8'hE1] = 8'h00;
    mreg[8'hE2] = 8'h00;
    mreg[8'hE3] = 8'h00;
  endtask
  initial begin
    seed = 32'h0001511F;
    fails = 0;
    samples_checked = 0;
    mpage = 8'h00;
    foreach (mreg[i]) mreg[i] = 8'h00;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, s_wdata, araddr} = 96'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("reset outputs", 16'h0001, {pu, ctrim, tmode, lraise, poff, pfast, aen});
    axi_rd(32'h00000010);
    chk("unmapped read", 32'h00000000, rdat);
    $display("reset test done");
    dwr(8'hFD, 8'h03);
    dwr(8'h00, 8'h01);
    drd(8'hE0);
    s = rnd();
    dwr(8'h0F, s[7:0]);
    dwr(8'h10, s[15:8]);
    chk("pull strengths", s[15:0], {pd, pu});
    drd(8'h0F);
    $display("pull test done");
    dwr(8'hE1, 8'h05);
    dwr(8'hE0, 8'hF6);
    chk("test mode", 1'b0, tmode);
    drd(8'hE1);
    dwr(8'hE0, 8'hF7);
    chk("test mode", 1'b1, tmode);
    for (int c = 1; c <= 12; c++) begin
      dwr(8'hE1, 8'(c));
      watch(100, 1'b0);
      chk("held switch", 12'h001 << (c - 1), acc);
    end
    dwr(8'hE1, 8'h00);
    watch(2000, 1'b0);
    chk("scanned switches", 12'hFFF, acc);
    $display("test mode test done");
    s = rnd();
    dwr(8'hE2, s[7:0]);
    dwr(8'hE3, s[15:8]);
    dwr(8'h12, 8'hFF);
    chk("trims", {s[2:0], s[15:8]}, {ctrim, rtrim, otrim});
    chk("thermal bits", 2'b11, {lraise, poff});
    drd(8'h12);
    drd(8'hE2);
    $display("trim test done");
    dwr(8'h00, 8'h10);
    watch(200, 1'b1);
    chk("blank sources", {12'h000, 1'b1}, {acc, pfast});
    drd(8'hE3);
    dwr(8'h00, 8'h01);
    watch(200, 1'b1);
    chk("running sources", 2'b10, {|acc, pfast});
    $display("soft shutdown test done");
    axi_wr(`HOST_CTRL_OFF, 32'h00000002);
    repeat (3) @(posedge aclk);
    chk("analog enable", 1'b0, aen);
    s = rnd();
    dwr(8'h10, s[7:0]);
    chk("pull-down strength", s[7:0], pd);
    drd(8'h0F);
    axi_wr(`HOST_CTRL_OFF, 32'h00000000);
    repeat (3) @(posedge aclk);
    chk("analog enable", 1'b1, aen);
    $display("hard shutdown test done");
    axi_wr(`HOST_CTRL_OFF, 32'h00000001);
    axi_wr(`HOST_CMD_OFF, {15'h0000, 1'b1, 8'h0F, ~mreg[8'h0F]});
    repeat (20) @(posedge aclk);
    axi_wr(`HOST_CTRL_OFF, 32'h00000000);
    dwr(8'hFD, 8'h03);
    drd(8'h0F);
    $display("serial reset test done");
    axi_wr(`HOST_CTRL_OFF, 32'h00000008);
    idle();
    mrec();
    chk("recovered", 4'h0, {tmode, ctrim});
    dwr(8'hE0, 8'hF7);
    drd(8'hE3);
    dwr(8'hE1, 8'h03);
    axi_wr(`HOST_CTRL_OFF, 32'h00000004);
    repeat (600) @(posedge aclk);
    axi_wr(`HOST_CTRL_OFF, 32'h00000000);
    idle();
    mrec();
    chk("periodic recovery", 1'b0, tmode);
    $display("recovery test done");
    finish_test();
  end
endmodule
